/* iupr_format.sv */
// package of shared constants and types, plus the fault-format view module
`timescale 1ns/1ps
`default_nettype none

package iupr_pkg;
	// register indices of the privileged register space
	localparam logic [7:0] IDX_FAULT_CTL    = 8'h01;
	localparam logic [7:0] IDX_DFAULT_VIEW  = 8'h02;
	localparam logic [7:0] IDX_TAG_STAGE    = 8'h03;
	localparam logic [7:0] IDX_ENTRY_STAGE  = 8'h04;
	localparam logic [7:0] IDX_FLUSH_NG     = 8'h05;
	localparam logic [7:0] IDX_FLUSH_ALL    = 8'h06;
	localparam logic [7:0] IDX_FLUSH_SINGLE = 8'h07;
	localparam logic [5:0] IDX_INTERRUPT_ENABLE_AND_MODE_HI    = 6'h02;
	localparam logic [7:0] IDX_PROF_PC      = 8'h10;
	localparam logic [7:0] IDX_EXC_PC       = 8'h11;
	localparam logic [7:0] IDX_IFAULT_VIEW  = 8'h12;

	// itlb geometry
	localparam int         ITLB_ENTRIES = 8;
	localparam int         PTR_W        = 3;
	localparam logic [2:0] PTR_RESET    = 3'h0;

	// field positions
	localparam int VPN_LO     = 13;
	localparam int VPN_HI     = 47;
	localparam int ASN_LO     = 39;
	localparam int ASN_HI     = 46;
	localparam int VPTB_LO    = 30;
	localparam int CTL_COMPACT = 2;
	localparam int CTL_WIDE    = 1;
	localparam int PTE_ASM    = 4;
	localparam int PTE_GH_LO  = 5;
	localparam int PTE_GH_HI  = 6;
	localparam int PTE_PFN_LO = 13;
	localparam int PTE_PFN_HI = 43;
	localparam int IER_LO     = 13;
	localparam int IER_HI     = 38;
	localparam int CM_LO      = 3;
	localparam int CM_HI      = 4;
	localparam int WR_IER_BIT = 1;
	localparam int WR_CM_BIT  = 0;

	// reset values
	localparam logic [25:0] IER_RESET  = 26'h0;
	localparam logic [33:0] VPTB_RESET = 34'h0;

	typedef enum logic [1:0] {
		IUPR_KERNEL     = 2'b00,
		IUPR_EXECUTIVE  = 2'b01,
		IUPR_SUPERVISOR = 2'b10,
		IUPR_USER       = 2'b11
	} iupr_mode_t;

	typedef struct packed {
		logic        valid;
		logic [34:0] vpn;
		logic [7:0]  address_space_tag;
		logic        asm_bit;
		logic [1:0]  gh;
		logic [30:0] pfn;
	} iupr_entry_t;

	typedef struct packed {
		logic        valid;
		logic [7:0]  index;
		logic [63:0] data;
	} iupr_wr_t;

	typedef struct packed {
		logic        valid;
		logic        is_interrupt;
		logic        priv_mode;
		logic [63:0] fault_pc;
		logic [63:0] next_pc;
	} iupr_exc_t;
endpackage

//////////////////////////////////////////////////////////////////////////////

module iupr_pte_format (
	// page table base and format selects
	input  wire logic [33:0] vptb,
	input  wire logic        wide,
	input  wire logic        compact,
	// faulting address and view
	input  wire logic [63:0] va,
	output logic      [63:0] view
);
	always_comb begin
		case ({compact, wide})
			2'b00:   view = {vptb[33:3], va[42:13], 3'h0};
			2'b01:   view = {vptb[33:8], va[47:13], 3'h0};
			2'b10:   view = {vptb, 8'h0, va[31:13], 3'h0};
			default: view = 64'h0; // R2
		endcase
	end
endmodule // iupr_pte_format

`default_nettype wire

/* iupr_regs.sv */
// privileged register bank of the instruction unit
//
// Contract
// R1 - data fault view gives pte address from fault address and control bits.
// R2 - view layout follows wide and compact bits; both set reads zero.
// R3 - tag write lands in a holding register, no entry changes.
// R4 - entry staging write retiring fills one entry with tag and entry.
// R5 - fill entry chosen round-robin, entry 0 first after reset.
// R6 - nonglobal flush clears entries without global bit; icache untouched.
// R7 - flush-all clears every entry and rewinds the fill pointer.
// R8 - single flush clears entries matching page, hint mask and address tag.
// R9 - single flush also clears matching pages with global bit set.
// R10 - single flush leaves the instruction cache alone.
// R11 - profiled pc register: pc in 63:2, bit 1 zero, bit 0 physical flag.
// R12 - exception pc updates on every exception; bit 0 flags privileged mode.
// R13 - faults and synchronous traps capture the faulting instruction pc.
// R14 - interrupts capture the pc of the next instruction.
// R15 - instruction fault view from exception pc and unit control bits.
// R16 - index bits 7:2 equal 000010 select enable-and-mode register.
// R17 - index bit 1 writes enables, bit 0 writes mode.
// R18 - read of enable-and-mode returns both fields.
// R19 - enable fields at 38:33, 32, 31, 30:29, 28:14, all read-write.
// R20 - trap enable bit 13 passes only per-mode enabled trap requests.
// R21 - current mode in 4:3: kernel, executive, supervisor, user.
// R22 - wide bit clear selects 43-bit layout, set selects 48-bit; with compact set the code gives the 32-bit layout, or zero if wide is set.
`timescale 1ns/1ps
`default_nettype none

module iupr_regs (
	// clock and reset
	input  wire logic                  clk,
	input  wire logic                  rst,
	// privileged register writes, taken when retired
	input  wire iupr_pkg::iupr_wr_t    priv_wr,
	// privileged register reads
	input  wire logic                  rd_valid,
	input  wire logic [7:0]            rd_index,
	output logic                       rd_ack,
	output logic      [63:0]           rd_data,
	// fault and exception events
	input  wire logic                  dfault_valid,
	input  wire logic [63:0]           dfault_va,
	input  wire iupr_pkg::iupr_exc_t   exc,
	input  wire logic                  prof_valid,
	input  wire logic [63:0]           prof_pc,
	input  wire logic                  prof_physical,
	// context and unit control
	input  wire logic [63:0]           process_context,
	input  wire logic [33:0]           ictl_vptb,
	input  wire logic                  ictl_wide,
	input  wire logic                  ictl_compact,
	// trap requests
	input  wire logic [3:0]            ast_requests,
	input  wire logic [3:0]            per_mode_async_trap_enables,
	// fetch lookup
	input  wire logic [63:0]           lookup_va,
	output logic                       lookup_hit,
	output logic      [30:0]           lookup_pfn,
	// state towards the pipeline
	output logic      [25:0]           int_enables,
	output iupr_pkg::iupr_mode_t       current_privilege,
	output logic      [3:0]            ast_pending,
	output logic      [iupr_pkg::ITLB_ENTRIES-1:0] itlb_valid
);

	//////////////////////////////////////////////////////////////////////////
	// write decode

	logic wr_ctl;
	logic wr_tag;
	logic wr_entry;
	logic wr_flush_ng;
	logic wr_flush_all;
	logic wr_flush_single;
	logic wr_interrupt_enable_and_mode;

	always_comb begin
		wr_ctl          = priv_wr.valid &&
			priv_wr.index == iupr_pkg::IDX_FAULT_CTL;
		wr_tag          = priv_wr.valid &&
			priv_wr.index == iupr_pkg::IDX_TAG_STAGE;
		wr_entry        = priv_wr.valid &&
			priv_wr.index == iupr_pkg::IDX_ENTRY_STAGE;
		wr_flush_ng     = priv_wr.valid &&
			priv_wr.index == iupr_pkg::IDX_FLUSH_NG;
		wr_flush_all    = priv_wr.valid &&
			priv_wr.index == iupr_pkg::IDX_FLUSH_ALL;
		wr_flush_single = priv_wr.valid &&
			priv_wr.index == iupr_pkg::IDX_FLUSH_SINGLE;
		wr_interrupt_enable_and_mode       = priv_wr.valid &&
			priv_wr.index[7:2] == iupr_pkg::IDX_INTERRUPT_ENABLE_AND_MODE_HI; // R16
	end

	//////////////////////////////////////////////////////////////////////////
	// fault address control and captured fault address

	logic [33:0] fault_vptb;
	logic        fault_wide;
	logic        fault_compact;
	logic [63:0] faulting_virtual_address;

	always_ff @(posedge clk) begin
		if (rst) begin
			fault_vptb    <= iupr_pkg::VPTB_RESET;
			fault_wide    <= 1'b0;
			fault_compact <= 1'b0;
		end else if (wr_ctl) begin
			fault_vptb    <= priv_wr.data[63:iupr_pkg::VPTB_LO];
			fault_wide    <= priv_wr.data[iupr_pkg::CTL_WIDE];
			fault_compact <= priv_wr.data[iupr_pkg::CTL_COMPACT];
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			faulting_virtual_address <= 64'h0;
		end else if (dfault_valid) begin
			faulting_virtual_address <= dfault_va;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// profiled pc and exception pc

	logic [63:0] profiled_instruction_pc;
	logic [63:0] exception_pc;

	always_ff @(posedge clk) begin
		if (rst) begin
			profiled_instruction_pc <= 64'h0;
		end else if (prof_valid) begin
			profiled_instruction_pc <= {prof_pc[63:2], 1'b0,
				prof_physical}; // R11
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			exception_pc <= 64'h0;
		end else if (exc.valid) begin // R12
			if (exc.is_interrupt) begin
				exception_pc <= {exc.next_pc[63:1], exc.priv_mode}; // R14
			end else begin
				exception_pc <= {exc.fault_pc[63:1], exc.priv_mode}; // R13
			end
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// fault format views

	logic [63:0] data_fault_pte_address_view;
	logic [63:0] instr_fault_pte_address_view;

	// R1 R22
	iupr_pte_format u_data_view (
		.vptb    (fault_vptb),
		.wide    (fault_wide),
		.compact (fault_compact),
		.va      (faulting_virtual_address),
		.view    (data_fault_pte_address_view)
	);

	// R15
	iupr_pte_format u_instr_view (
		.vptb    (ictl_vptb),
		.wide    (ictl_wide),
		.compact (ictl_compact),
		.va      (exception_pc),
		.view    (instr_fault_pte_address_view)
	);

	//////////////////////////////////////////////////////////////////////////
	// enables and current mode

	always_ff @(posedge clk) begin
		if (rst) begin
			int_enables <= iupr_pkg::IER_RESET;
		end else if (wr_interrupt_enable_and_mode && priv_wr.index[iupr_pkg::WR_IER_BIT]) begin
			int_enables <= priv_wr.data[iupr_pkg::IER_HI:iupr_pkg::IER_LO];
		end // R17 R19
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			current_privilege <= iupr_pkg::IUPR_KERNEL;
		end else if (wr_interrupt_enable_and_mode && priv_wr.index[iupr_pkg::WR_CM_BIT]) begin
			current_privilege <= iupr_pkg::iupr_mode_t'(
				priv_wr.data[iupr_pkg::CM_HI:iupr_pkg::CM_LO]); // R17 R21
		end
	end

	// bit 0 of the enables is the trap enable
	always_ff @(posedge clk) begin
		if (rst) begin
			ast_pending <= 4'h0;
		end else begin
			ast_pending <= int_enables[0] ?
				(ast_requests & per_mode_async_trap_enables) : 4'h0; // R20
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// itlb staging, fill pointer and entries

	localparam int PTR_W_L = iupr_pkg::PTR_W;

	logic [34:0]                   staged_vpn;
	logic [PTR_W_L-1:0]            fill_ptr;
	iupr_pkg::iupr_entry_t         entries [iupr_pkg::ITLB_ENTRIES];
	logic [iupr_pkg::ITLB_ENTRIES-1:0] single_hit;
	logic [iupr_pkg::ITLB_ENTRIES-1:0] lookup_match;
	logic [iupr_pkg::ITLB_ENTRIES-1:0] itlb_valid_next;

	always_ff @(posedge clk) begin
		if (rst) begin
			staged_vpn <= 35'h0;
		end else if (wr_tag) begin
			staged_vpn <= priv_wr.data[iupr_pkg::VPN_HI:iupr_pkg::VPN_LO]; // R3
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			fill_ptr <= iupr_pkg::PTR_RESET; // R5
		end else if (wr_flush_all) begin
			fill_ptr <= iupr_pkg::PTR_RESET; // R7
		end else if (wr_entry) begin
			fill_ptr <= fill_ptr + 3'h1; // R5
		end
	end

	function automatic logic [34:0] gh_mask(input logic [1:0] gh);
		case (gh)
			2'b00:   gh_mask = 35'h7ffffffff;
			2'b01:   gh_mask = 35'h7fffffff8;
			2'b10:   gh_mask = 35'h7ffffffc0;
			default: gh_mask = 35'h7fffffe00;
		endcase
	endfunction

	genvar gi;
	generate
		for (gi = 0; gi < iupr_pkg::ITLB_ENTRIES; gi++) begin : g_entry
			logic [34:0] msk;
			logic        page_eq;
			logic        look_eq;
			assign msk     = gh_mask(entries[gi].gh);
			assign page_eq = ((entries[gi].vpn ^ priv_wr.data[47:13]) &
				msk) == 35'h0;
			assign look_eq = ((entries[gi].vpn ^ lookup_va[47:13]) &
				msk) == 35'h0;
			assign single_hit[gi] = page_eq && (entries[gi].asm_bit ||
				entries[gi].address_space_tag ==
				process_context[iupr_pkg::ASN_HI:iupr_pkg::ASN_LO]); // R8 R9
			assign lookup_match[gi] = entries[gi].valid && look_eq &&
				(entries[gi].asm_bit || entries[gi].address_space_tag ==
				process_context[iupr_pkg::ASN_HI:iupr_pkg::ASN_LO]);
			assign itlb_valid_next[gi] = entries[gi].valid;
		end
	endgenerate

	// flushes never touch the instruction cache: no port reaches it
	always_ff @(posedge clk) begin
		if (rst) begin
			for (int i = 0; i < iupr_pkg::ITLB_ENTRIES; i++) begin
				entries[i] <= '0;
			end
		end else begin
			for (int i = 0; i < iupr_pkg::ITLB_ENTRIES; i++) begin
				if (wr_flush_all) begin
					entries[i].valid <= 1'b0; // R7
				end else if (wr_flush_ng && !entries[i].asm_bit) begin
					entries[i].valid <= 1'b0; // R6
				end else if (wr_flush_single && single_hit[i]) begin
					entries[i].valid <= 1'b0; // R8 R9 R10
				end else if (wr_entry && fill_ptr == i[PTR_W_L-1:0]) begin
					entries[i].valid   <= 1'b1; // R4
					entries[i].vpn     <= staged_vpn;
					entries[i].address_space_tag     <= process_context[
						iupr_pkg::ASN_HI:iupr_pkg::ASN_LO];
					entries[i].asm_bit <= priv_wr.data[iupr_pkg::PTE_ASM];
					entries[i].gh      <= priv_wr.data[
						iupr_pkg::PTE_GH_HI:iupr_pkg::PTE_GH_LO];
					entries[i].pfn     <= priv_wr.data[
						iupr_pkg::PTE_PFN_HI:iupr_pkg::PTE_PFN_LO];
				end
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			itlb_valid <= '0;
		end else begin
			itlb_valid <= itlb_valid_next;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// fetch lookup

	logic [30:0] next_lookup_pfn;

	always_comb begin
		next_lookup_pfn = 31'h0;
		for (int i = 0; i < iupr_pkg::ITLB_ENTRIES; i++) begin
			if (lookup_match[i]) begin
				next_lookup_pfn = entries[i].pfn;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			lookup_hit <= 1'b0;
			lookup_pfn <= 31'h0;
		end else begin
			lookup_hit <= |lookup_match;
			lookup_pfn <= next_lookup_pfn;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// read path

	logic [63:0] next_rd_data;

	always_comb begin
		next_rd_data = 64'h0;
		if (rd_index[7:2] == iupr_pkg::IDX_INTERRUPT_ENABLE_AND_MODE_HI) begin
			next_rd_data[iupr_pkg::IER_HI:iupr_pkg::IER_LO] = int_enables;
			next_rd_data[iupr_pkg::CM_HI:iupr_pkg::CM_LO] =
				current_privilege; // R18
		end else begin
			case (rd_index)
				iupr_pkg::IDX_DFAULT_VIEW:
					next_rd_data = data_fault_pte_address_view; // R1
				iupr_pkg::IDX_PROF_PC:
					next_rd_data = profiled_instruction_pc; // R11
				iupr_pkg::IDX_EXC_PC:
					next_rd_data = exception_pc;
				iupr_pkg::IDX_IFAULT_VIEW:
					next_rd_data = instr_fault_pte_address_view; // R15
				default:
					next_rd_data = 64'h0;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			rd_ack  <= 1'b0;
			rd_data <= 64'h0;
		end else begin
			rd_ack  <= rd_valid;
			rd_data <= rd_valid ? next_rd_data : 64'h0;
		end
	end

endmodule // iupr_regs

`default_nettype wire

/* iupr_pipe_model.sv */
// pipeline model issuing privileged register moves
`timescale 1ns/1ps
`default_nettype none

module iupr_pipe_model (
	// clock
	input  wire logic               clk,
	// requests
	output iupr_pkg::iupr_wr_t      priv_wr,
	output logic                    rd_valid,
	output logic      [7:0]         rd_index,
	// answers
	input  wire logic               rd_ack,
	input  wire logic [63:0]        rd_data
);
	initial begin
		priv_wr = '0;
		rd_valid = 1'b0;
		rd_index = 8'h00;
	end

	task automatic wr(input logic [7:0] idx, input logic [63:0] v);
		@(negedge clk);
		priv_wr = '{valid: 1'b1, index: idx, data: v};
		@(negedge clk);
		// released fields carry no stale value
		priv_wr = '{valid: 1'b0, index: ~idx, data: ~v};
	endtask

	task automatic rd(input logic [7:0] idx, output logic [63:0] v);
		@(negedge clk);
		rd_valid = 1'b1;
		rd_index = idx;
		@(negedge clk);
		v = (rd_ack === 1'b1) ? rd_data : 64'hx;
		rd_valid = 1'b0;
		rd_index = ~idx;
	endtask
endmodule // iupr_pipe_model
`default_nettype wire

/* iupr_regs_asserts.sv */
// concurrent checks on the privileged register bank ports
`timescale 1ns/1ps
`default_nettype none

module iupr_regs_asserts (
	// clock and reset
	input wire logic                 clk,
	input wire logic                 rst,
	// requests
	input wire iupr_pkg::iupr_wr_t   priv_wr,
	input wire logic                 rd_valid,
	input wire logic [3:0]           ast_requests,
	input wire logic [3:0]           per_mode_async_trap_enables,
	// answers and state
	input wire logic                 rd_ack,
	input wire logic [63:0]          rd_data,
	input wire logic [25:0]          int_enables,
	input wire iupr_pkg::iupr_mode_t current_privilege,
	input wire logic [3:0]           ast_pending,
	input wire logic [7:0]           itlb_valid
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	logic sel;
	assign sel = priv_wr.valid && priv_wr.index[7:2] == iupr_pkg::IDX_INTERRUPT_ENABLE_AND_MODE_HI;

	a_ack_next: assert property (rd_valid |=> rd_ack)
		else $error("read not answered");
	a_ack_cause: assert property (rd_ack |-> $past(rd_valid))
		else $error("answer without read");
	a_data_quiet: assert property (!rd_ack |-> rd_data == 64'h0)
		else $error("read data outside answer");
	a_mode_write: assert property (sel && priv_wr.index[0] |=>
		current_privilege == $past(priv_wr.data[4:3]))
		else $error("mode not written");
	a_mode_hold: assert property (!(sel && priv_wr.index[0]) |=>
		$stable(current_privilege))
		else $error("mode changed without write");
	a_ier_write: assert property (sel && priv_wr.index[1] |=>
		int_enables == $past(priv_wr.data[38:13]))
		else $error("enables not written");
	a_ier_hold: assert property (!(sel && priv_wr.index[1]) |=>
		$stable(int_enables))
		else $error("enables changed without write");
	a_ast_gate: assert property ($stable(int_enables) &&
		int_enables == $past(int_enables, 2) |-> ast_pending ==
		($past(ast_requests) & $past(per_mode_async_trap_enables)
		& {4{int_enables[0]}}))
		else $error("trap pending mismatch");
	a_flush_clears: assert property (priv_wr.valid &&
		priv_wr.index == iupr_pkg::IDX_FLUSH_ALL |-> ##2 itlb_valid == 8'h00)
		else $error("flush all left entries");
endmodule // iupr_regs_asserts

bind iupr_regs iupr_regs_asserts u_asserts (.clk, .rst, .priv_wr, .rd_valid,
	.ast_requests, .per_mode_async_trap_enables, .rd_ack, .rd_data,
	.int_enables, .current_privilege, .ast_pending, .itlb_valid);
`default_nettype wire

/* iupr_tb.sv */
// testbench for the instruction unit privileged register bank
`timescale 1ns/1ps
`default_nettype none

module tb;
	logic                 clk, rst, rd_valid, rd_ack, dfault_valid;
	logic                 prof_valid, prof_physical, ictl_wide, ictl_compact;
	logic                 lookup_hit;
	logic [7:0]           rd_index, itlb_valid;
	logic [63:0]          rd_data, dfault_va, prof_pc, process_context;
	logic [63:0]          lookup_va, d, c;
	logic [33:0]          ictl_vptb;
	logic [3:0]           ast_requests, per_mode_async_trap_enables;
	logic [3:0]           ast_pending;
	logic [30:0]          lookup_pfn;
	logic [25:0]          int_enables;
	iupr_pkg::iupr_mode_t current_privilege;
	iupr_pkg::iupr_wr_t   priv_wr;
	iupr_pkg::iupr_exc_t  exc;
	int                   num_errors, n_checks, i;
	localparam logic [63:0] VA_A = 64'h0000_4567_89ab_c000;
	localparam logic [63:0] VA_B = 64'h0000_7654_3210_e000;
	localparam logic [63:0] PTE_A = 64'h0000_0000_0246_8000;
	localparam logic [63:0] CTX_A = 64'h0000_2a80_0000_0000;
	localparam logic [63:0] PC = 64'h1234_5678_9abc_def4;

	iupr_regs DUT (.clk, .rst, .priv_wr, .rd_valid, .rd_index, .rd_ack,
		.rd_data, .dfault_valid, .dfault_va, .exc, .prof_valid, .prof_pc,
		.prof_physical, .process_context, .ictl_vptb, .ictl_wide,
		.ictl_compact, .ast_requests, .per_mode_async_trap_enables,
		.lookup_va, .lookup_hit, .lookup_pfn, .int_enables,
		.current_privilege, .ast_pending, .itlb_valid);
	iupr_pipe_model u_pipe (.clk, .priv_wr, .rd_valid, .rd_index, .rd_ack,
		.rd_data);

	//////////////////////////////////////////////////////////////////////
	function automatic logic [63:0] fmt(logic [63:0] k, logic [63:0] va);
		case (k[2:1])
			2'b00: fmt = {k[63:33], va[42:13], 3'h0};
			2'b01: fmt = {k[63:38], va[47:13], 3'h0};
			2'b10: fmt = {k[63:30], 8'h0, va[31:13], 3'h0};
			default: fmt = 64'h0;
		endcase
	endfunction

	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		n_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic rdchk(input logic [7:0] idx, input logic [63:0] exp);
		u_pipe.rd(idx, d);
		chk(d, exp);
	endtask

	task automatic tick(input int n);
		repeat (n) @(negedge clk);
	endtask

	task automatic fill(input logic [63:0] va, input logic [63:0] pte);
		u_pipe.wr(8'h03, va);
		u_pipe.wr(8'h04, pte);
		tick(2);
	endtask

	task automatic finish_test;
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	//////////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	initial begin
		#100000;
		num_errors++;
		finish_test;
	end

	initial begin
		{rst, dfault_valid, prof_valid, prof_physical} = 4'hf;
		{ictl_wide, ictl_compact, dfault_va, prof_pc} = '0;
		{process_context, lookup_va, ictl_vptb, ast_requests} = '0;
		per_mode_async_trap_enables = 4'h0;
		{dfault_valid, prof_valid, prof_physical} = 3'h0;
		exc = '0;
		num_errors = 0;
		n_checks = 0;
		tick(4);
		rst = 1'b0;
		rdchk(8'h08, 64'h0);
		u_pipe.wr(8'h0a, '1);
		rdchk(8'h08, 64'h0000_007f_ffff_e000);
		for (i = 0; i < 4; i++) begin
			u_pipe.wr(8'h09, 64'(i) << 3);
			chk(current_privilege, 64'(i));
		end
		rdchk(8'h0b, 64'h0000_007f_ffff_e018);
		u_pipe.wr(8'h0b, 64'h0);
		rdchk(8'h09, 64'h0);
		rdchk(8'hff, 64'h0);
		ast_requests = 4'hf;
		per_mode_async_trap_enables = 4'h5;
		u_pipe.wr(8'h0a, 64'h2000);
		tick(2);
		chk(ast_pending, 4'h5);
		u_pipe.wr(8'h0a, 64'h0);
		tick(2);
		chk(ast_pending, 4'h0);
		{prof_pc, prof_physical, prof_valid} = {64'hffff_ffff_ffff_ffff, 2'b11};
		tick(1);
		prof_valid = 1'b0;
		rdchk(8'h10, 64'hffff_ffff_ffff_fffd);
		exc = '{1'b1, 1'b0, 1'b1, PC, PC + 64'h4};
		tick(1);
		exc.valid = 1'b0;
		rdchk(8'h11, PC | 64'h1);
		exc = '{1'b1, 1'b1, 1'b0, PC, PC + 64'h4};
		tick(1);
		exc.valid = 1'b0;
		rdchk(8'h11, PC + 64'h4);
		ictl_vptb = 34'h2_aaaa_aaab;
		dfault_va = 64'h0000_9abc_def0_1234;
		dfault_valid = 1'b1;
		tick(1);
		dfault_valid = 1'b0;
		for (i = 0; i < 4; i++) begin
			{ictl_compact, ictl_wide} = i[1:0];
			c = {ictl_vptb, 27'h0, i[1:0], 1'b0};
			rdchk(8'h12, fmt(c, PC + 64'h4));
			u_pipe.wr(8'h01, c ^ 64'hffff_fffc_0000_0000);
			rdchk(8'h02, fmt(c ^ 64'hffff_fffc_0000_0000, dfault_va));
		end
		process_context = CTX_A;
		u_pipe.wr(8'h03, VA_A);
		tick(2);
		chk(itlb_valid, 8'h00);
		u_pipe.wr(8'h04, PTE_A);
		tick(2);
		chk(itlb_valid, 8'h01);
		lookup_va = VA_A;
		tick(1);
		chk({lookup_hit, lookup_pfn}, {1'b1, PTE_A[43:13]});
		fill(VA_B, 64'h10);
		fill(VA_A, 64'h0);
		chk(itlb_valid, 8'h07);
		u_pipe.wr(8'h05, 64'h0);
		tick(2);
		chk(itlb_valid, 8'h02);
		u_pipe.wr(8'h06, 64'h0);
		tick(2);
		chk(itlb_valid, 8'h00);
		fill(VA_A, PTE_A);
		chk(itlb_valid, 8'h01);
		fill(VA_B, 64'h10);
		process_context = 64'h0;
		u_pipe.wr(8'h07, VA_A);
		tick(2);
		chk(itlb_valid, 8'h03);
		u_pipe.wr(8'h07, VA_B);
		tick(2);
		chk(itlb_valid, 8'h01);
		process_context = CTX_A;
		u_pipe.wr(8'h07, VA_A);
		tick(2);
		chk(itlb_valid, 8'h00);
		fill(VA_A, PTE_A | 64'h60);
		u_pipe.wr(8'h07, VA_A ^ 64'h2000);
		tick(2);
		chk(itlb_valid, 8'h00);
		chk(lookup_hit, 64'h0);
		finish_test;
	end
endmodule // tb
`default_nettype wire
